// ### dcbcp_pkg.sv
// package: constants, register map and types of the bridge control block
package dcbcp_pkg;
   // clock rate and timing figures
   localparam int unsigned CLK_HZ          = 25000000;
   localparam int unsigned BLANK_NS        = 3000;    // blanking interval
   localparam int unsigned CHOP_OFF_NS     = 25500;   // chop_off_time typ
   localparam int unsigned PROTECT_OFF_US  = 1200;    // protect_off_time typ
   localparam int unsigned BLANK_CYC    = (BLANK_NS * 25) / 1000;     // 75
   localparam int unsigned CHOP_OFF_CYC = (CHOP_OFF_NS * 25) / 1000;  // 637
   localparam int unsigned PROTECT_CYC  = PROTECT_OFF_US * 25;        // 30000
   localparam int unsigned CNT_W        = 16;

   // register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_IRQ_ST = 12'h008;
   localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
   localparam logic [11:0] OFS_IRQ_CL = 12'h010;

   // control register fields
   localparam int CTRL_DIR   = 0;
   localparam int CTRL_EN    = 1;
   localparam int CTRL_DECAY = 2;
   localparam int CTRL_LIMIT = 3;
   localparam int CTRL_STBYN = 4;
   localparam logic [4:0] CTRL_RESET = 5'h18;  // limit high, standby off

   // event bits (irq status, enable, clear share the layout)
   localparam int EV_SHORT = 0;
   localparam int EV_LIMIT = 1;
   localparam int EV_WARN  = 2;
   localparam int EV_SHUT  = 3;
   localparam int EV_UV    = 4;
   localparam int EV_W     = 5;

   // bridge leg drive codes
   typedef enum logic [1:0] {DCBCP_LEG_Z, DCBCP_LEG_LO, DCBCP_LEG_HI}
      dcbcp_leg_t;
   typedef enum {DCBCP_IDLE, DCBCP_DRIVE, DCBCP_CHOP, DCBCP_LATCH}
      dcbcp_state_t;
endpackage

// ### dcbcp_timer.sv
// down-counting interval timer used for blank, chop and retry intervals
`timescale 1ns/100ps
module dcbcp_timer
(
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          start,
   input  wire logic [dcbcp_pkg::CNT_W-1:0]   load,
   output logic                               busy
);
   logic [dcbcp_pkg::CNT_W-1:0] count;
   logic [dcbcp_pkg::CNT_W-1:0] next_count;

   // restart wins over counting so a new trigger always gets a full interval
   always_comb
   begin
      next_count = count;
      if (start)
         next_count = load;
      else if (count != '0)
         next_count = count - 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else
         count <= next_count;
   end

   assign busy = (count != '0);
endmodule

// ### dcbcp_bridge.sv
// full-bridge control, chopping, protection and apb registers
// What this block does
// - over peak current, chop in mixed decay for fixed off-time, then redrive
// - peak regulation runs only while limit_select is high
// - ignore current comparator for about 3 us after each output transition
// - standby_n low holds both bridge outputs high-impedance
// - short sets fault latch, outputs off until protect_off_time expires
// - shutdown temperature disables outputs until its flag clears
// - thermal warning asserts fault output, bridge keeps driving
// - limit_select low: sense over 500 mV latches outputs off
// - current-limit latch holds fault low, retries after protect timer
// - fault_flag_n low for short, limit latch, warning, undervoltage
// - supply lockout keeps bridge outputs off
// - enabled drive: direction 1 gives a high b low, 0 reverse
// - enable and decay low: fast decay opposite direction, z near zero
// - enable low, decay high: brake with both outputs high
`timescale 1ns/100ps
module dcbcp_bridge
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        peak_trip,
   input  wire logic        sense_trip,
   input  wire logic        short_detect,
   input  wire logic        temp_warn,
   input  wire logic        temp_shutdown,
   input  wire logic        load_supply_low,
   input  wire logic        pump_voltage_low,
   input  wire logic        current_near_zero,
   output logic             bridge_out_a,
   output logic             bridge_out_a_oe_n,
   output logic             bridge_out_b,
   output logic             bridge_out_b_oe_n,
   output logic             pump_enable,
   output logic             fault_flag_n_out,
   output logic             fault_flag_n_oe_n,
   output logic             irq
);
   // ------------------------------------------------------------
   // state and next values
   // ------------------------------------------------------------
   logic [4:0]                      ctrl;
   logic [4:0]                      next_ctrl;
   logic [dcbcp_pkg::EV_W-1:0]      ev_status;
   logic [dcbcp_pkg::EV_W-1:0]      next_ev_status;
   logic [dcbcp_pkg::EV_W-1:0]      ev_enable;
   logic [dcbcp_pkg::EV_W-1:0]      next_ev_enable;
   logic [31:0]                     next_prdata;
   logic                            next_pready;
   logic                            next_pslverr;
   dcbcp_pkg::dcbcp_state_t         state;
   dcbcp_pkg::dcbcp_state_t         next_state;
   logic                            short_latch;
   logic                            next_short_latch;
   logic                            limit_latch;
   logic                            next_limit_latch;
   dcbcp_pkg::dcbcp_leg_t           leg_a;
   dcbcp_pkg::dcbcp_leg_t           leg_b;
   dcbcp_pkg::dcbcp_leg_t           next_leg_a;
   dcbcp_pkg::dcbcp_leg_t           next_leg_b;
   logic                            chop_phase;
   logic                            next_chop_phase;
   logic                            next_out_a;
   logic                            next_oe_a_n;
   logic                            next_out_b;
   logic                            next_oe_b_n;
   logic                            next_fault_oe_n;
   logic                            next_irq;
   logic                            blank_busy;
   logic                            chop_busy;
   logic                            retry_busy;
   logic                            blank_start;
   logic                            chop_start;
   logic                            retry_start;
   logic [dcbcp_pkg::EV_W-1:0]      ev_raw;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   // legs of a table mode given direction bit
   function automatic dcbcp_pkg::dcbcp_leg_t pick(input logic d,
                                                   input logic on_when);
      pick = (d == on_when) ? dcbcp_pkg::DCBCP_LEG_HI
                            : dcbcp_pkg::DCBCP_LEG_LO;
   endfunction

   wire logic dir       = ctrl[dcbcp_pkg::CTRL_DIR];
   wire logic enable    = ctrl[dcbcp_pkg::CTRL_EN];
   wire logic decay_sel = ctrl[dcbcp_pkg::CTRL_DECAY];
   wire logic limit_sel = ctrl[dcbcp_pkg::CTRL_LIMIT];
   wire logic standby_n = ctrl[dcbcp_pkg::CTRL_STBYN];
   wire logic lockout   = load_supply_low | pump_voltage_low;
   wire logic off_force = !standby_n | lockout | temp_shutdown
                        | short_latch | limit_latch;
   wire logic acc       = psel & penable & !pready;
   wire logic wr        = acc & pwrite;
   // current comparator masked during blanking
   wire logic cmp_peak  = peak_trip & !blank_busy & limit_sel;
   wire logic cmp_limit = sense_trip & !blank_busy & !limit_sel;

   // ------------------------------------------------------------
   // timers
   // ------------------------------------------------------------
   dcbcp_timer u_blank (.pclk(pclk), .presetn(presetn), .start(blank_start),
      .load(dcbcp_pkg::CNT_W'(dcbcp_pkg::BLANK_CYC)), .busy(blank_busy));
   dcbcp_timer u_chop (.pclk(pclk), .presetn(presetn), .start(chop_start),
      .load(dcbcp_pkg::CNT_W'(dcbcp_pkg::CHOP_OFF_CYC)), .busy(chop_busy));
   dcbcp_timer u_retry (.pclk(pclk), .presetn(presetn), .start(retry_start),
      .load(dcbcp_pkg::CNT_W'(dcbcp_pkg::PROTECT_CYC)), .busy(retry_busy));

   // ------------------------------------------------------------
   // protection latches and chop state
   // ------------------------------------------------------------
   // both latch kinds share one retry timer, started when a latch is set
   always_comb
   begin
      next_state       = state;
      next_short_latch = short_latch;
      next_limit_latch = limit_latch;
      next_chop_phase  = chop_phase;
      chop_start       = 1'b0;
      retry_start      = 1'b0;
      if ((short_latch | limit_latch) & !retry_busy & !retry_start)
      begin
         next_short_latch = 1'b0;
         next_limit_latch = 1'b0;
      end
      if (short_detect & standby_n)
      begin
         next_short_latch = 1'b1;
         retry_start      = 1'b1;
      end
      else if (cmp_limit & (state == dcbcp_pkg::DCBCP_DRIVE))
      begin
         next_limit_latch = 1'b1;
         retry_start      = 1'b1;
      end
      case (state)
         dcbcp_pkg::DCBCP_IDLE:
            if (!off_force & enable)
               next_state = dcbcp_pkg::DCBCP_DRIVE;
         dcbcp_pkg::DCBCP_DRIVE:
            if (off_force | retry_start)
               next_state = dcbcp_pkg::DCBCP_LATCH;
            else if (!enable)
               next_state = dcbcp_pkg::DCBCP_IDLE;
            else if (cmp_peak)
            begin
               next_state      = dcbcp_pkg::DCBCP_CHOP;
               chop_start      = 1'b1;
               next_chop_phase = 1'b0;
            end
         dcbcp_pkg::DCBCP_CHOP:
            if (off_force | retry_start)
               next_state = dcbcp_pkg::DCBCP_LATCH;
            else if (!chop_busy)
               next_state = dcbcp_pkg::DCBCP_IDLE;
            else
               next_chop_phase = !chop_phase;   // mixed decay alternates
         dcbcp_pkg::DCBCP_LATCH:
            if (!off_force & !retry_start)
               next_state = dcbcp_pkg::DCBCP_IDLE;
         default:
            next_state = dcbcp_pkg::DCBCP_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state       <= dcbcp_pkg::DCBCP_IDLE;
         short_latch <= 1'b0;
         limit_latch <= 1'b0;
         chop_phase  <= 1'b0;
      end
      else
      begin
         state       <= next_state;
         short_latch <= next_short_latch;
         limit_latch <= next_limit_latch;
         chop_phase  <= next_chop_phase;
      end
   end

   // ------------------------------------------------------------
   // output mapping
   // ------------------------------------------------------------
   // the control table; forced-off cases leave both legs floating
   always_comb
   begin
      next_leg_a = dcbcp_pkg::DCBCP_LEG_Z;
      next_leg_b = dcbcp_pkg::DCBCP_LEG_Z;
      if (off_force | (state == dcbcp_pkg::DCBCP_LATCH))
      begin
         next_leg_a = dcbcp_pkg::DCBCP_LEG_Z;
         next_leg_b = dcbcp_pkg::DCBCP_LEG_Z;
      end
      else if (state == dcbcp_pkg::DCBCP_CHOP)
      begin
         // driven leg chops, opposite leg stays high
         next_leg_a = dir ? (chop_phase ? dcbcp_pkg::DCBCP_LEG_HI
            : dcbcp_pkg::DCBCP_LEG_LO) : dcbcp_pkg::DCBCP_LEG_HI;
         next_leg_b = dir ? dcbcp_pkg::DCBCP_LEG_HI : (chop_phase
            ? dcbcp_pkg::DCBCP_LEG_HI : dcbcp_pkg::DCBCP_LEG_LO);
      end
      else if (enable)
      begin
         next_leg_a = pick(dir, 1'b1);
         next_leg_b = pick(dir, 1'b0);
      end
      else if (decay_sel)
      begin
         next_leg_a = dcbcp_pkg::DCBCP_LEG_HI;
         next_leg_b = dcbcp_pkg::DCBCP_LEG_HI;
      end
      else if (!current_near_zero)
      begin
         next_leg_a = pick(dir, 1'b0);
         next_leg_b = pick(dir, 1'b1);
      end
   end

   // each change of a leg restarts blanking
   assign blank_start = (next_leg_a != leg_a) | (next_leg_b != leg_b);

   always_comb
   begin
      next_out_a  = (next_leg_a == dcbcp_pkg::DCBCP_LEG_HI);
      next_oe_a_n = (next_leg_a == dcbcp_pkg::DCBCP_LEG_Z);
      next_out_b  = (next_leg_b == dcbcp_pkg::DCBCP_LEG_HI);
      next_oe_b_n = (next_leg_b == dcbcp_pkg::DCBCP_LEG_Z);
      // fault drives low only: warning keeps bridge running
      next_fault_oe_n = !(short_latch | limit_latch | temp_warn
                          | lockout);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         leg_a             <= dcbcp_pkg::DCBCP_LEG_Z;
         leg_b             <= dcbcp_pkg::DCBCP_LEG_Z;
         bridge_out_a      <= 1'b0;
         bridge_out_a_oe_n <= 1'b1;
         bridge_out_b      <= 1'b0;
         bridge_out_b_oe_n <= 1'b1;
         fault_flag_n_out  <= 1'b0;
         fault_flag_n_oe_n <= 1'b1;
         pump_enable       <= 1'b0;
      end
      else
      begin
         leg_a             <= next_leg_a;
         leg_b             <= next_leg_b;
         bridge_out_a      <= next_out_a;
         bridge_out_a_oe_n <= next_oe_a_n;
         bridge_out_b      <= next_out_b;
         bridge_out_b_oe_n <= next_oe_b_n;
         fault_flag_n_out  <= 1'b0;
         fault_flag_n_oe_n <= next_fault_oe_n;
         pump_enable       <= standby_n;
      end
   end

   // ------------------------------------------------------------
   // apb registers and interrupt
   // ------------------------------------------------------------
   assign ev_raw = {lockout, temp_shutdown, temp_warn, limit_latch,
                    short_latch};

   // set wins over a clear in the same cycle
   always_comb
   begin
      next_ctrl      = ctrl;
      next_ev_enable = ev_enable;
      next_ev_status = ev_status;
      next_prdata    = 32'h0000_0000;
      next_pready    = acc;
      next_pslverr   = 1'b0;
      if (wr & hit(paddr, dcbcp_pkg::OFS_CTRL))
         next_ctrl = pwdata[4:0];
      if (wr & hit(paddr, dcbcp_pkg::OFS_IRQ_EN))
         next_ev_enable = pwdata[dcbcp_pkg::EV_W-1:0];
      if (wr & hit(paddr, dcbcp_pkg::OFS_IRQ_CL))
         next_ev_status = ev_status & ~pwdata[dcbcp_pkg::EV_W-1:0];
      next_ev_status = next_ev_status | ev_raw;
      if (acc)
      begin
         case (paddr)
            dcbcp_pkg::OFS_CTRL:   next_prdata = {27'h0, ctrl};
            dcbcp_pkg::OFS_STATUS: next_prdata = {23'h0, !fault_flag_n_oe_n,
               bridge_out_b_oe_n, bridge_out_a_oe_n, 1'b0, ev_raw};
            dcbcp_pkg::OFS_IRQ_ST: next_prdata = {27'h0, ev_status};
            dcbcp_pkg::OFS_IRQ_EN: next_prdata = {27'h0, ev_enable};
            dcbcp_pkg::OFS_IRQ_CL: next_prdata = 32'h0000_0000;
            default:               next_pslverr = 1'b1;
         endcase
      end
      next_irq = |(ev_status & ev_enable);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl      <= dcbcp_pkg::CTRL_RESET;
         ev_status <= '0;
         ev_enable <= '0;
         prdata    <= 32'h0000_0000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         irq       <= 1'b0;
      end
      else
      begin
         ctrl      <= next_ctrl;
         ev_status <= next_ev_status;
         ev_enable <= next_ev_enable;
         prdata    <= next_prdata;
         pready    <= next_pready;
         pslverr   <= next_pslverr;
         irq       <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_standby_float: assert property (@(posedge pclk) disable iff (!presetn)
      !standby_n |=> bridge_out_a_oe_n && bridge_out_b_oe_n)
      else $error("bridge driven in standby");
   a_shutdown_off: assert property (@(posedge pclk) disable iff (!presetn)
      temp_shutdown |=> bridge_out_a_oe_n && bridge_out_b_oe_n)
      else $error("bridge driven during thermal shutdown");
   a_lockout_off: assert property (@(posedge pclk) disable iff (!presetn)
      lockout |=> bridge_out_a_oe_n && bridge_out_b_oe_n)
      else $error("bridge driven under supply lockout");
   a_fault_warn: assert property (@(posedge pclk) disable iff (!presetn)
      temp_warn |=> !fault_flag_n_oe_n)
      else $error("warning did not pull fault low");
   a_short_latch: assert property (@(posedge pclk) disable iff (!presetn)
      short_detect && standby_n |=> short_latch ##1 !fault_flag_n_oe_n)
      else $error("short not latched");
   a_retry_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(limit_latch) |-> limit_latch [*8])
      else $error("limit latch released early");
   a_blank_mask: assert property (@(posedge pclk) disable iff (!presetn)
      blank_busy |-> !cmp_peak && !cmp_limit)
      else $error("comparator seen during blanking");
   a_forward_map: assert property (@(posedge pclk) disable iff (!presetn)
      state == dcbcp_pkg::DCBCP_DRIVE && !off_force && enable && dir
      && !cmp_peak && !retry_start |=> bridge_out_a && !bridge_out_b)
      else $error("forward mapping wrong");
   a_brake_map: assert property (@(posedge pclk) disable iff (!presetn)
      !off_force && state != dcbcp_pkg::DCBCP_LATCH
      && state != dcbcp_pkg::DCBCP_CHOP && !enable && decay_sel
      |=> bridge_out_a && bridge_out_b)
      else $error("brake mapping wrong");
   a_chop_high: assert property (@(posedge pclk) disable iff (!presetn)
      state == dcbcp_pkg::DCBCP_CHOP && dir && !off_force
      |=> bridge_out_b && !bridge_out_b_oe_n)
      else $error("opposite leg not high while chopping");
   a_peak_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !limit_sel |-> !chop_start)
      else $error("chop without peak regulation");
endmodule

// ### dcbcp_host.sv
// host model: apb master that sequences the bridge control register
`timescale 1ns/100ps
module dcbcp_host
(
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // --------------------------------------------
   // bus cycles
   // --------------------------------------------
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end

   // request held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // leave standby with control word c, then let the pump settle for 10000 cycles
   task automatic wake(input logic [31:0] c);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, dcbcp_pkg::OFS_CTRL, c, q, e);
      repeat (10000) @(posedge pclk);
   endtask
endmodule

// ### testbench.sv
// testbench: random and corner drive of the bridge control block
`timescale 1ns/100ps
module testbench;
   localparam logic [1:0] LZ = dcbcp_pkg::DCBCP_LEG_Z;
   localparam logic [1:0] LL = dcbcp_pkg::DCBCP_LEG_LO;
   localparam logic [1:0] LH = dcbcp_pkg::DCBCP_LEG_HI;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, r;
   logic        a, aoe, b, boe, pump, fout, foe, irq, e;
   logic [7:0]  ev;   // peak,sense,short,warn,shut,uv load,uv pump,near0
   int          fail_count, checks, seed;

   initial pclk = 1'b0;
   always #20 pclk = ~pclk;

   dcbcp_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   dcbcp_bridge u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .peak_trip(ev[0]), .sense_trip(ev[1]),
      .short_detect(ev[2]), .temp_warn(ev[3]), .temp_shutdown(ev[4]),
      .load_supply_low(ev[5]), .pump_voltage_low(ev[6]),
      .current_near_zero(ev[7]), .bridge_out_a(a),
      .bridge_out_a_oe_n(aoe), .bridge_out_b(b),
      .bridge_out_b_oe_n(boe), .pump_enable(pump),
      .fault_flag_n_out(fout), .fault_flag_n_oe_n(foe), .irq(irq));

   // --------------------------------------------
   // checks and helpers
   // --------------------------------------------
   task automatic fail(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
         fail($sformatf("value %h, wanted %h", got, exp));
   endtask
   function automatic logic [1:0] code(input logic oe_n, input logic v);
      return oe_n ? LZ : (v ? LH : LL);
   endfunction
   task automatic chk_legs(input logic [3:0] exp);
      checks++;
      if ({code(aoe, a), code(boe, b)} !== exp)
         fail("bridge legs");
   endtask
   // expected legs from {standby_n,limit,decay,enable,dir}
   function automatic logic [3:0] legs(input logic [4:0] c,
                                       input logic nz);
      if (!c[4])
         return {LZ, LZ};
      if (c[1])
         return c[0] ? {LH, LL} : {LL, LH};
      if (c[2])
         return {LH, LH};
      if (nz)
         return {LZ, LZ};
      return c[0] ? {LL, LH} : {LH, LL};
   endfunction
   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      u_host.xfer(1'b1, ad, d, q, e);
   endtask
   task automatic rd(input logic [11:0] ad);
      u_host.xfer(1'b0, ad, 32'h0, q, e);
   endtask
   task automatic set(input logic [4:0] c);
      wr(dcbcp_pkg::OFS_CTRL, {27'h0, c});
      repeat (3) @(posedge pclk);
   endtask
   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // one trip latches the bridge off until the shared retry ends
   task automatic latch(input int i);
      pulse(i);
      chk_legs({LZ, LZ});
      chk(foe, 1'b0);
      repeat (29900) @(posedge pclk);
      chk_legs({LZ, LZ});
      repeat (200) @(posedge pclk);
      chk_legs({LH, LL});
      chk(foe, 1'b1);
   endtask
   task automatic wrap_up();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // hang guard: all tests need about 75000 cycles
   initial
   begin
      repeat (95000) @(posedge pclk);
      fail("timeout");
      wrap_up();
   end

   // --------------------------------------------
   // main sequence
   // --------------------------------------------
   initial
   begin
      presetn = 1'b0;
      ev = 8'h00;
      fail_count = 0;
      checks = 0;
      seed = 32'hadd4;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk_legs({LH, LL});
      rd(dcbcp_pkg::OFS_CTRL);
      chk(q, {27'h0, dcbcp_pkg::CTRL_RESET});
      pulse(7);
      ev[7] <= 1'b1;
      repeat (3) @(posedge pclk);
      chk_legs({LZ, LZ});
      ev[7] <= 1'b0;
      rd(12'h020);
      chk(e, 1'b1);
      set(5'h0b);
      chk_legs({LZ, LZ});
      chk(pump, 1'b0);
      u_host.wake(32'h1b);
      chk(pump, 1'b1);
      $display("test reset and standby done");
      // two brake corners first, then random control words
      for (int k = 0; k < 14; k++)
      begin
         r = $random(seed);
         r[4:0] = (k < 2) ? 5'h14 + k[4:0] : {1'b1, r[3:0]};
         ev[7] <= r[5];
         set(r[4:0]);
         chk_legs(legs(r[4:0], r[5]));
      end
      ev[7] <= 1'b0;
      set(5'h1b);
      repeat (80) @(posedge pclk);
      pulse(0);
      chk({boe, b}, 2'b01);
      q[0] = a;
      @(posedge pclk);
      chk({aoe, a}, {1'b0, ~q[0]});
      repeat (700) @(posedge pclk);
      chk_legs({LH, LL});
      set(5'h1a);
      pulse(0);
      chk_legs({LL, LH});
      set(5'h12);
      repeat (80) @(posedge pclk);
      pulse(0);
      chk_legs({LL, LH});
      $display("test chop done");
      set(5'h1b);
      repeat (80) @(posedge pclk);
      latch(2);
      set(5'h13);
      repeat (80) @(posedge pclk);
      latch(1);
      $display("test latch done");
      // thermal and supply events with the interrupt masked
      wr(dcbcp_pkg::OFS_IRQ_CL, 32'h1f);
      wr(dcbcp_pkg::OFS_IRQ_EN, 32'h0);
      for (int i = 3; i < 7; i++)
      begin
         ev[i] <= 1'b1;
         repeat (3) @(posedge pclk);
         chk_legs((i == 3) ? {LH, LL} : {LZ, LZ});
         chk(foe, i == 4);
         chk(fout, 1'b0);
         chk(irq, 1'b0);
         // live status: fault, b float, a float, spare, event bits
         rd(dcbcp_pkg::OFS_STATUS);
         chk(q, {23'h0, i != 4, i != 3, i != 3, 1'b0,
                 5'h01 << ((i < 5) ? i - 1 : 4)});
         ev[i] <= 1'b0;
         repeat (80) @(posedge pclk);
      end
      rd(dcbcp_pkg::OFS_IRQ_ST);
      chk(q, 32'h1c);
      wr(dcbcp_pkg::OFS_IRQ_EN, 32'h1c);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1);
      wr(dcbcp_pkg::OFS_IRQ_CL, 32'h1c);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      rd(dcbcp_pkg::OFS_IRQ_ST);
      chk(q, 32'h0);
      $display("test events done");
      wrap_up();
   end
endmodule
